//--- design/adsps_pkg.sv
// Purpose: Shared constants for the converter serial pin shell.
// Assumes: One system clock at 40 MHz samples every pin except the asynchronous reset.
// Notes:   Clock mode encodings are the two-bit values of the mode field.
package adsps_pkg;
  localparam logic [1:0] ADSPS_MODE_FALL0 = 2'h0;
  localparam logic [1:0] ADSPS_MODE_FALL1 = 2'h1;
  localparam logic [1:0] ADSPS_MODE_FALL2 = 2'h2;
  localparam logic [1:0] ADSPS_MODE_RISE  = 2'h3;
  localparam int         ADSPS_WORD_W     = 16;
  localparam int         ADSPS_CNT_W      = 5;
  localparam logic [4:0] ADSPS_CNT_RST    = 5'h00;
  localparam logic [15:0] ADSPS_WORD_RST  = 16'h0000;
  localparam logic [9:0] ADSPS_DAC_RST    = 10'h000;
endpackage

//--- design/adsps_shell.sv
// Purpose: Pin-level serial host port of a combined ADC/DAC device.
// Assumes: Serial clock well below the 40 MHz system clock (bench 5 MHz).
// Notes:   Chip select, serial clock, serial data, load strobe and done pass two flip-flops; serial edges are found by sampling.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - The end-of-conversion output is active low and results are valid only after it falls.
// - In clock modes 00, 01 and 10 each output bit shifts on the serial clock falling edge.
// - In clock mode 11 each output bit shifts on the serial clock rising edge.
// - While chip select is high the serial data output is high impedance.
// - The port acts only while chip select is low for the whole transfer.
// - Serial input is sampled on each serial clock falling edge.
// - While the load strobe is low the DAC output registers follow the input registers.
module adsps_shell
  import adsps_pkg::*;
#(
  parameter int WORD_W = ADSPS_WORD_W
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        CS_N_IN,
  input  wire logic        SCLK_IN,
  input  wire logic        DIN_IN,
  input  wire logic        OUTPUT_LOAD_STROBE_N_IN,
  input  wire logic [1:0]  CLK_MODE_IN,
  input  wire logic        CONV_DONE_IN,
  input  wire logic [WORD_W-1:0] RESULT_IN,
  input  wire logic [9:0]  DAC_IN_REG_IN,
  output logic             DOUT_OUT,
  output logic             DOUT_OE_N_OUT,
  output logic             EOC_N_OUT,
  output logic [WORD_W-1:0] RX_WORD_OUT,
  output logic             RX_VALID_OUT,
  output logic [9:0]       DAC_OUT_REG_OUT
);

  logic [1:0] cs_s_q, sclk_s_q, din_s_q, ld_s_q, done_s_q;
  logic       sclk_prev_q;
  logic [ADSPS_CNT_W-1:0] cnt_q, cnt_d;
  logic [WORD_W-1:0] rx_q, rx_d, tx_q, tx_d, rxw_q, rxw_d;
  logic       rxv_q, rxv_d, dout_q, dout_d, oen_q, oen_d, eoc_q, eoc_d;
  logic [9:0] dac_q, dac_d;
  logic       cs_act, fall, rise, shift_ev;

  // Two-flop synchronisers; only the second stage is read below.
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cs_s_q   <= 2'h3;
      sclk_s_q <= 2'h0;
      din_s_q  <= 2'h0;
      ld_s_q   <= 2'h3;
      done_s_q <= 2'h0;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_s_q   <= {cs_s_q[0], CS_N_IN};
      sclk_s_q <= {sclk_s_q[0], SCLK_IN};
      din_s_q  <= {din_s_q[0], DIN_IN};
      ld_s_q   <= {ld_s_q[0], OUTPUT_LOAD_STROBE_N_IN};
      done_s_q <= {done_s_q[0], CONV_DONE_IN};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  assign cs_act = !cs_s_q[1];
  assign fall   = sclk_prev_q & !sclk_s_q[1];
  assign rise   = !sclk_prev_q & sclk_s_q[1];
  // Mode 11 shifts on rise, all other modes on fall.
  assign shift_ev = (CLK_MODE_IN == ADSPS_MODE_RISE) ? rise : fall;

  always_comb begin
    cnt_d  = cnt_q;
    rx_d   = rx_q;
    tx_d   = tx_q;
    rxw_d  = rxw_q;
    rxv_d  = 1'b0;
    dout_d = dout_q;
    oen_d  = !cs_act;
    eoc_d  = eoc_q;
    dac_d  = dac_q;
    if (!cs_act) begin
      cnt_d = ADSPS_CNT_RST;
      tx_d  = RESULT_IN;
    end else begin
      if (fall) begin
        rx_d = {rx_q[WORD_W-2:0], din_s_q[1]};
        if (cnt_q == ADSPS_CNT_W'(WORD_W - 1)) begin
          cnt_d = ADSPS_CNT_RST;
          rxw_d = {rx_q[WORD_W-2:0], din_s_q[1]};
          rxv_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      if (shift_ev) begin
        dout_d = tx_q[WORD_W-1];
        tx_d   = {tx_q[WORD_W-2:0], 1'b0};
      end
    end
    // A new result pulls the flag low; a frame reading it releases it.
    if (done_s_q[1]) begin
      eoc_d = 1'b0;
    end else if (cs_act) begin
      eoc_d = 1'b1;
    end
    // Transparent while the strobe is low; holds the last value otherwise.
    if (!ld_s_q[1]) begin
      dac_d = DAC_IN_REG_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cnt_q  <= ADSPS_CNT_RST;
      rx_q   <= ADSPS_WORD_RST;
      tx_q   <= ADSPS_WORD_RST;
      rxw_q  <= ADSPS_WORD_RST;
      rxv_q  <= 1'b0;
      dout_q <= 1'b0;
      oen_q  <= 1'b1;
      eoc_q  <= 1'b1;
      dac_q  <= ADSPS_DAC_RST;
    end else begin
      cnt_q  <= cnt_d;
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      rxw_q  <= rxw_d;
      rxv_q  <= rxv_d;
      dout_q <= dout_d;
      oen_q  <= oen_d;
      eoc_q  <= eoc_d;
      dac_q  <= dac_d;
    end
  end

  assign DOUT_OUT        = dout_q;
  assign DOUT_OE_N_OUT   = oen_q;
  assign EOC_N_OUT       = eoc_q;
  assign RX_WORD_OUT     = rxw_q;
  assign RX_VALID_OUT    = rxv_q;
  assign DAC_OUT_REG_OUT = dac_q;

endmodule

`default_nettype wire

//--- dv/adsps_assertions.sv
// Purpose: Pin checks. Assumes: Sync delay under five clocks. Notes: Bound.
`timescale 1ns/100ps
`default_nettype none
module adsps_checker (input wire logic MCLK_IN, RSTN_IN, CS_N_IN,
  CONV_DONE_IN, DOUT_OE_N_OUT, EOC_N_OUT, RX_VALID_OUT,
  OUTPUT_LOAD_STROBE_N_IN, input wire logic [9:0] DAC_IN_REG_IN,
  input wire logic [9:0] DAC_OUT_REG_OUT);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  property p_hiz; CS_N_IN[*4] |-> DOUT_OE_N_OUT; endproperty
  a_hiz: assert property (p_hiz) else $error("dout driven");
  property p_on; !CS_N_IN[*4] |-> !DOUT_OE_N_OUT; endproperty
  a_on: assert property (p_on) else $error("dout idle");
  property p_eoc; CONV_DONE_IN[*5] |-> !EOC_N_OUT; endproperty
  a_eoc: assert property (p_eoc) else $error("eoc high");
  property p_vld; RX_VALID_OUT |-> ##1 !RX_VALID_OUT; endproperty
  a_vld: assert property (p_vld) else $error("valid too long");
  property p_ld;
    (!OUTPUT_LOAD_STROBE_N_IN && $stable(DAC_IN_REG_IN))[*4]
      |-> DAC_OUT_REG_OUT == DAC_IN_REG_IN;
  endproperty
  a_ld: assert property (p_ld) else $error("dac not transparent");
  property p_hold;
    OUTPUT_LOAD_STROBE_N_IN[*4] |=> $stable(DAC_OUT_REG_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("dac moved");
  cover property ($fell(EOC_N_OUT));
  cover property ($fell(DOUT_OE_N_OUT));
  cover property ($rose(DOUT_OE_N_OUT));
endmodule
bind adsps_shell adsps_checker adsps_checker_i (.MCLK_IN, .RSTN_IN, .CS_N_IN,
  .CONV_DONE_IN, .DOUT_OE_N_OUT, .EOC_N_OUT, .RX_VALID_OUT,
  .OUTPUT_LOAD_STROBE_N_IN, .DAC_IN_REG_IN, .DAC_OUT_REG_OUT);
`default_nettype wire

//--- dv/adsps_master.sv
// Purpose: Serial master model. Assumes: 5 MHz link. Notes: Clock idles low.
`timescale 1ns/100ps
`default_nettype none
module adsps_master (output logic cs_n, sclk, din, input wire logic dout);
  initial {cs_n, sclk, din} = 3'h4;
  task automatic xfer(logic r, logic [15:0] t, int n, output logic [15:0] q);
    cs_n = 1'b0;
    #203;
    for (int i = 0; i < n; i++) begin
      {sclk, din} = {1'b1, t[15-i]};
      #100;
      if (!r && i > 0) q = {q[14:0], dout};
      sclk = 1'b0;
      #100;
      if (r) q = {q[14:0], dout};
    end
    #100;
    if (!r) q = {q[14:0], dout};
    // Data is flipped on release so a stale bit is never mistaken for live.
    {cs_n, din} = {1'b1, ~din};
    #100;
  endtask
endmodule
`default_nettype wire

//--- dv/adsps_shell_tb.sv
// Purpose: Shell bench. Assumes: Model drives pins. Notes: Self-checking.
`timescale 1ns/100ps
`default_nettype none
module adsps_shell_tb;
  logic mclk = 1'b0, rst_n = 1'b0, ld_n = 1'b1, done = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] res = 16'h0000, q, rxw;
  logic [9:0] dac = 10'h000, dac_o;
  logic cs_n, sclk, din, dout, eoc_n, oe_n, rxv;
  int n_mismatch = 0, checked = 0, n_rxv = 0;
  always #12.5 mclk = ~mclk;
  // One pulse per whole word; cut frames must leave no pulse behind.
  always @(posedge mclk) if (rxv === 1'b1) n_rxv++;
  adsps_shell adsps_shell_i (.MCLK_IN(mclk), .RSTN_IN(rst_n), .CS_N_IN(cs_n),
    .SCLK_IN(sclk), .DIN_IN(din), .OUTPUT_LOAD_STROBE_N_IN(ld_n),
    .CLK_MODE_IN(mode), .CONV_DONE_IN(done), .RESULT_IN(res),
    .DAC_IN_REG_IN(dac), .DOUT_OUT(dout), .DOUT_OE_N_OUT(oe_n),
    .EOC_N_OUT(eoc_n), .RX_WORD_OUT(rxw), .RX_VALID_OUT(rxv),
    .DAC_OUT_REG_OUT(dac_o));
  adsps_master adsps_master_i (.cs_n, .sclk, .din, .dout);
  task automatic chk(string s, logic [15:0] g, e);
    checked++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("Error %s exp %h got %h", s, e, g);
  endtask
  task automatic t_side;
    @(posedge mclk) {done, dac} <= {1'b1, 10'h2B7};
    repeat (6) @(posedge mclk);
    chk("eoc", eoc_n, 1'b0);
    chk("hold", dac_o, 10'h000);
    @(posedge mclk) {done, ld_n} <= 2'h0;
    repeat (6) @(posedge mclk);
    chk("load", dac_o, 10'h2B7);
  endtask
  task automatic t_ser;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk) {mode, res} <= {m[1:0], 16'hA5C3 ^ m[15:0]};
      adsps_master_i.xfer(m == 3, 16'hFFFF, m + 3, q);
      adsps_master_i.xfer(m == 3, 16'h3C5A + m[15:0], 16, q);
      repeat (8) @(posedge mclk);
      chk("dout", q, 16'hA5C3 ^ m[15:0]);
      chk("rxw", rxw, 16'h3C5A + m[15:0]);
      chk("rxv", n_rxv, m + 1);
      chk("oe", oe_n, 1'b1);
      chk("eocr", eoc_n, 1'b1);
    end
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_side;
    t_ser;
    tally_and_finish;
  end
endmodule
`default_nettype wire
